/* File: hw/eur_defines.vh */
/*
 Constants of the thread register file block: register file codes,
 architecture register types, bus register offsets and fields.
 Assumes inclusion by bare name from the design file.
*/
`ifndef EUR_DEFINES_VH
`define EUR_DEFINES_VH
`define EUR_FILE_GRF 2'h0
`define EUR_FILE_ARF 2'h1
`define EUR_FILE_IMM 2'h3
`define EUR_ARF_NULL 4'h0
`define EUR_ARF_ADDR 4'h1
`define EUR_ARF_ACC 4'h2
`define EUR_ARF_FLAG 4'h3
`define EUR_ARF_CHEN 4'h4
`define EUR_ARF_RSV5 4'h5
`define EUR_ARF_SP 4'h6
`define EUR_ARF_STATE 4'h7
`define EUR_ARF_CTRL 4'h8
`define EUR_ARF_NOTIF 4'h9
`define EUR_ARF_IP 4'hA
`define EUR_ARF_TDEP 4'hB
`define EUR_ARF_TSTAMP 4'hC
`define EUR_ARF_FLOW 4'hD
`define EUR_ARF_RSVE 4'hE
`define EUR_A0_BYTE_MASK 32'h0000FFFF
`define EUR_REG_BYTES 32
`define EUR_OFF_CTRL 8'h00
`define EUR_OFF_STATUS 8'h04
`define EUR_OFF_INFL_SEL 8'h08
`define EUR_OFF_INFL_DATA 8'h0C
`define EUR_OFF_DROP_CNT 8'h10
`define EUR_CTRL_TS_EN 0
`define EUR_STAT_DONE_LSB 16
`define EUR_SEL_THREAD_LSB 8
`define EUR_HTRANS_ACT_BIT 1
`define EUR_CTRL_RESET 32'h00000001
`endif

/* File: hw/eur_thread_regfile.v */
/*
 Per-thread general and a0 register storage, with one shared timestamp, of an execution
 unit: operand read/write ports, send issue with in-flight scoreboard,
 writeback port and an AHB-Lite slave for control and status.
 Assumes synchronous inputs on clock_i and a single AHB-Lite master.
*/
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "eur_defines.vh"
module eur_thread_regfile #(
	parameter TID_W = 1,
	parameter [15:0] FID_VALID = 16'h00FF
) (
	input wire clock_i,
	input wire rst_i,
	input wire hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire [31:0] hwdata_i,
	input wire hready_i,
	output wire [31:0] hrdata_o,
	output wire hreadyout_o,
	output wire hresp_o,
	input wire rd_req_i,
	input wire [TID_W-1:0] rd_thread_i,
	input wire [1:0] rd_file_i,
	input wire [7:0] rd_register_number_field_i,
	input wire [4:0] rd_subreg_i,
	input wire rd_indirect_i,
	input wire [2:0] rd_a0_sel_i,
	input wire [9:0] rd_imm_off_i,
	input wire [31:0] rd_imm_i,
	output wire [255:0] rd_data_o,
	output wire rd_valid_o,
	output wire rd_stall_o,
	output wire [3:0] rd_arf_type_o,
	output wire rd_arf_rsvd_o,
	input wire wr_req_i,
	input wire [TID_W-1:0] wr_thread_i,
	input wire [1:0] wr_file_i,
	input wire [7:0] wr_register_number_field_i,
	input wire [4:0] wr_subreg_i,
	input wire [1:0] wr_esize_i,
	input wire [1:0] wr_hstride_i,
	input wire [5:0] wr_count_i,
	input wire [255:0] wr_data_i,
	output wire wr_stall_o,
	input wire send_req_i,
	input wire [TID_W-1:0] send_thread_i,
	input wire [3:0] send_fid_i,
	input wire send_eot_i,
	input wire send_desc_imm_i,
	input wire [31:0] send_desc_i,
	input wire [6:0] send_src_reg_i,
	input wire [3:0] send_mlen_i,
	input wire send_dst_null_i,
	input wire [6:0] send_dst_reg_i,
	input wire [4:0] send_rlen_i,
	output wire msg_valid_o,
	output wire [TID_W-1:0] msg_thread_o,
	output wire [3:0] msg_fid_o,
	output wire [31:0] msg_desc_o,
	output wire [3:0] msg_mlen_o,
	output wire msg_eot_o,
	output wire [255:0] msg_data_o,
	output wire send_refused_o,
	output wire thread_end_o,
	input wire wb_valid_i,
	input wire [TID_W-1:0] wb_thread_i,
	input wire [6:0] wb_base_i,
	input wire [4:0] wb_offset_i,
	input wire [255:0] wb_data_i
);
	localparam THREADS = 1 << TID_W;
	localparam IW = TID_W + 7;
	reg [255:0] general_register_file [0:THREADS*128-1];
	reg [THREADS*128-1:0] infl_r;
	reg [THREADS*128-1:0] a0_r;
	reg [63:0] tstamp_r;
	reg [THREADS-1:0] hung_r;
	reg [THREADS-1:0] done_r;
	reg [31:0] ctrl_r;
	reg [31:0] sel_r;
	reg [15:0] drop_cnt_r;
	reg [31:0] hrdata_r;
	reg hreadyout_r;
	reg hresp_r;
	reg ahb_wr_r;
	reg [7:0] ahb_addr_r;
	reg [255:0] rd_data_r;
	reg rd_valid_r;
	reg rd_stall_r;
	reg [3:0] rd_type_r;
	reg rd_rsvd_r;
	reg wr_stall_r;
	reg msg_valid_r;
	reg [TID_W-1:0] msg_thread_r;
	reg [3:0] msg_fid_r;
	reg [31:0] msg_desc_r;
	reg [3:0] msg_mlen_r;
	reg msg_eot_r;
	reg [255:0] msg_data_r;
	reg refused_r;
	reg end_r;

	// Flat index of a register inside the shared storage
	function [IW-1:0] gidx(input [TID_W-1:0] t, input [6:0] r);
		gidx = {t, r};
	endfunction
	// Range of registers starting at base, wrapping inside 128
	function [127:0] range_mask(input [6:0] base, input [4:0] len);
		integer j;
		reg [6:0] p;
		begin
			range_mask = 128'h0;
			p = base;
			for (j = 0; j < 32; j = j + 1) begin
				if (j < len)
					range_mask[p] = 1'b1;
				p = p + 7'h01;
			end
		end
	endfunction
	// Byte write mask from subregister, element size, stride and count
	function [31:0] byte_mask(input [4:0] sub, input [1:0] esz, input [1:0] hs,
		input [5:0] cnt);
		integer e;
		integer b;
		integer pos;
		integer stride;
		begin
			byte_mask = 32'h0;
			stride = (hs == 2'h0) ? 0 : ((1 << (hs - 2'h1)) << esz);
			for (e = 0; e < 32; e = e + 1) begin
				for (b = 0; b < 4; b = b + 1) begin
					pos = sub + e * stride + b;
					if (e < cnt && b < (1 << esz) && pos < `EUR_REG_BYTES)
						byte_mask[pos] = 1'b1;
				end
			end
		end
	endfunction
	// Expand byte mask to a bit mask over one register
	function [255:0] bit_mask(input [31:0] m);
		integer k;
		begin
			for (k = 0; k < 32; k = k + 1)
				bit_mask[k*8 +: 8] = {8{m[k]}};
		end
	endfunction
	// Image of a populated architecture register, zero elsewhere
	function [255:0] arf_image(input [7:0] rn, input [127:0] a0v, input [63:0] ts);
		begin
			arf_image = 256'h0;
			if (rn[3:0] == 4'h0) begin
				case (rn[7:4])
				`EUR_ARF_ADDR: arf_image = {128'h0, a0v};
				`EUR_ARF_TSTAMP: arf_image = {192'h0, ts};
				default: arf_image = 256'h0;
				endcase
			end
		end
	endfunction
	function is_rsvd(input [3:0] ty);
		is_rsvd = (ty == `EUR_ARF_RSV5) || (ty == `EUR_ARF_RSVE);
	endfunction
	// Operand read decode
	reg [127:0] rd_a0;
	reg [15:0] rd_elem;
	reg [11:0] rd_addr;
	reg [6:0] rd_reg;
	reg [4:0] rd_byte;
	reg [511:0] rd_pair;
	reg rd_busy;
	reg [255:0] rd_val;
	always @* begin
		rd_a0 = a0_r[rd_thread_i*128 +: 128];
		rd_elem = rd_a0[rd_a0_sel_i*16 +: 16];
		rd_addr = rd_elem[11:0] + {2'h0, rd_imm_off_i};
		rd_reg = rd_indirect_i ? rd_addr[11:5] : rd_register_number_field_i[6:0];
		rd_byte = rd_indirect_i ? rd_addr[4:0] : rd_subreg_i;
		rd_pair = {general_register_file[gidx(rd_thread_i, rd_reg + 7'h01)], general_register_file[gidx(rd_thread_i, rd_reg)]};
		rd_busy = 1'b0;
		rd_val = 256'h0;
		case (rd_file_i)
		`EUR_FILE_GRF: begin
			rd_val = rd_pair[rd_byte*8 +: 256];
			rd_busy = infl_r[gidx(rd_thread_i, rd_reg)] ||
				(rd_byte != 5'h0 && infl_r[gidx(rd_thread_i, rd_reg + 7'h01)]);
		end
		`EUR_FILE_ARF: begin
			rd_pair = {256'h0, arf_image(rd_register_number_field_i, rd_a0, tstamp_r)};
			rd_val = rd_pair[rd_subreg_i*8 +: 256];
		end
		`EUR_FILE_IMM: rd_val = {224'h0, rd_imm_i};
		default: rd_val = 256'h0;
		endcase
	end
	// Destination write decode
	reg [31:0] wr_bm;
	reg [255:0] wr_mask;
	reg wr_grf;
	reg wr_a0;
	reg wr_busy;
	always @* begin
		wr_bm = byte_mask(wr_subreg_i, wr_esize_i, wr_hstride_i, wr_count_i);
		wr_busy = infl_r[gidx(wr_thread_i, wr_register_number_field_i[6:0])] && wr_file_i == `EUR_FILE_GRF;
		wr_grf = wr_req_i && wr_file_i == `EUR_FILE_GRF && !wr_busy;
		// Only a0 is writable; null, read-only and unpopulated targets drop
		wr_a0 = wr_req_i && wr_file_i == `EUR_FILE_ARF &&
			wr_register_number_field_i == {`EUR_ARF_ADDR, 4'h0};
		wr_mask = bit_mask(wr_a0 ? (wr_bm & `EUR_A0_BYTE_MASK) : wr_bm);
	end
	// Send decode
	reg eot_eff;
	reg send_ok;
	reg [31:0] desc_eff;
	always @* begin
		eot_eff = send_eot_i && send_desc_imm_i;
		send_ok = send_req_i && !hung_r[send_thread_i] &&
			!(eot_eff && !send_dst_null_i);
		desc_eff = send_desc_imm_i ? send_desc_i : a0_r[send_thread_i*128 +: 32];
	end
	// Storage, never reset; writeback placed after so it wins a collision
	always @(posedge clock_i) begin
		if (wr_grf)
			general_register_file[gidx(wr_thread_i, wr_register_number_field_i[6:0])] <=
				(general_register_file[gidx(wr_thread_i, wr_register_number_field_i[6:0])] & ~wr_mask) | (wr_data_i & wr_mask);
		if (wb_valid_i)
			general_register_file[gidx(wb_thread_i, wb_base_i + {2'h0, wb_offset_i})] <= wb_data_i;
	end
	// AHB-Lite slave, zero wait states, registered read data
	wire ahb_go = hsel_i && htrans_i[`EUR_HTRANS_ACT_BIT] && hready_i;
	reg [31:0] stat_v;
	reg [31:0] rd_mux;
	integer i;
	integer th;
	always @* begin
		stat_v = 32'h0;
		for (i = 0; i < THREADS; i = i + 1) begin
			stat_v[i] = hung_r[i];
			stat_v[`EUR_STAT_DONE_LSB + i] = done_r[i];
		end
		case (haddr_i[7:0])
		`EUR_OFF_CTRL: rd_mux = ctrl_r;
		`EUR_OFF_STATUS: rd_mux = stat_v;
		`EUR_OFF_INFL_SEL: rd_mux = sel_r;
		`EUR_OFF_INFL_DATA: rd_mux = infl_r[{sel_r[`EUR_SEL_THREAD_LSB +: TID_W], sel_r[1:0], 5'h0} +: 32];
		`EUR_OFF_DROP_CNT: rd_mux = {16'h0, drop_cnt_r};
		default: rd_mux = 32'h0;
		endcase
	end
	// Control state
	reg [THREADS*128-1:0] set_v;
	reg [THREADS*128-1:0] clr_v;
	reg [THREADS-1:0] stat_clr;
	reg [THREADS-1:0] done_clr;
	always @* begin
		set_v = {THREADS*128{1'b0}};
		clr_v = {THREADS*128{1'b0}};
		if (wb_valid_i)
			clr_v[gidx(wb_thread_i, wb_base_i + {2'h0, wb_offset_i})] = 1'b1;
		if (send_ok && !send_dst_null_i)
			set_v[send_thread_i*128 +: 128] = range_mask(send_dst_reg_i, send_rlen_i);
		stat_clr = {THREADS{1'b0}};
		done_clr = {THREADS{1'b0}};
		if (ahb_wr_r && ahb_addr_r == `EUR_OFF_STATUS) begin
			stat_clr = hwdata_i[THREADS-1:0];
			done_clr = hwdata_i[`EUR_STAT_DONE_LSB +: THREADS];
		end
	end
	always @(posedge clock_i) begin
		if (rst_i) begin
			infl_r <= {THREADS*128{1'b0}};
			a0_r <= {THREADS*128{1'b0}};
			tstamp_r <= 64'h0;
			hung_r <= {THREADS{1'b0}};
			done_r <= {THREADS{1'b0}};
			ctrl_r <= `EUR_CTRL_RESET;
			sel_r <= 32'h0;
			drop_cnt_r <= 16'h0;
			hrdata_r <= 32'h0;
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
			ahb_wr_r <= 1'b0;
			ahb_addr_r <= 8'h0;
			rd_data_r <= 256'h0;
			rd_valid_r <= 1'b0;
			rd_stall_r <= 1'b0;
			rd_type_r <= 4'h0;
			rd_rsvd_r <= 1'b0;
			wr_stall_r <= 1'b0;
			msg_valid_r <= 1'b0;
			msg_thread_r <= {TID_W{1'b0}};
			msg_fid_r <= 4'h0;
			msg_desc_r <= 32'h0;
			msg_mlen_r <= 4'h0;
			msg_eot_r <= 1'b0;
			msg_data_r <= 256'h0;
			refused_r <= 1'b0;
			end_r <= 1'b0;
		end else begin
			infl_r <= (infl_r & ~clr_v) | set_v;
			if (ctrl_r[`EUR_CTRL_TS_EN])
				tstamp_r <= tstamp_r + 64'h1;
			if (wr_a0)
				a0_r[wr_thread_i*128 +: 128] <= (a0_r[wr_thread_i*128 +: 128] & ~wr_mask[127:0]) |
					(wr_data_i[127:0] & wr_mask[127:0]);
			ahb_wr_r <= ahb_go && hwrite_i;
			ahb_addr_r <= haddr_i[7:0];
			if (ahb_go && !hwrite_i)
				hrdata_r <= rd_mux;
			if (ahb_wr_r && ahb_addr_r == `EUR_OFF_CTRL)
				ctrl_r <= hwdata_i;
			if (ahb_wr_r && ahb_addr_r == `EUR_OFF_INFL_SEL)
				sel_r <= hwdata_i;
			rd_valid_r <= rd_req_i && !rd_busy;
			rd_stall_r <= rd_req_i && rd_busy;
			if (rd_req_i && !rd_busy)
				rd_data_r <= rd_val;
			rd_type_r <= (rd_file_i == `EUR_FILE_ARF) ? rd_register_number_field_i[7:4] : `EUR_ARF_NULL;
			rd_rsvd_r <= rd_req_i && rd_file_i == `EUR_FILE_ARF && is_rsvd(rd_register_number_field_i[7:4]);
			wr_stall_r <= wr_req_i && wr_busy;
			// Descriptor and payload are passed on unchecked
			msg_valid_r <= send_ok && FID_VALID[send_fid_i];
			if (send_ok) begin
				msg_thread_r <= send_thread_i;
				msg_fid_r <= send_fid_i;
				msg_desc_r <= desc_eff;
				msg_mlen_r <= send_mlen_i;
				msg_eot_r <= eot_eff;
				msg_data_r <= general_register_file[gidx(send_thread_i, send_src_reg_i)];
			end
			if (send_ok && !FID_VALID[send_fid_i])
				drop_cnt_r <= drop_cnt_r + 16'h1;
			refused_r <= send_req_i && !send_ok;
			end_r <= send_ok && eot_eff;
			// Hardware set wins over a software clear in the same cycle
			for (th = 0; th < THREADS; th = th + 1) begin
				hung_r[th] <= (hung_r[th] && !stat_clr[th]) ||
					(send_req_i && send_thread_i == th && eot_eff && !send_dst_null_i);
				done_r[th] <= (done_r[th] && !done_clr[th]) ||
					(send_ok && eot_eff && send_thread_i == th);
			end
		end
	end
	assign hrdata_o = hrdata_r;
	assign hreadyout_o = hreadyout_r;
	assign hresp_o = hresp_r;
	assign rd_data_o = rd_data_r;
	assign rd_valid_o = rd_valid_r;
	assign rd_stall_o = rd_stall_r;
	assign rd_arf_type_o = rd_type_r;
	assign rd_arf_rsvd_o = rd_rsvd_r;
	assign wr_stall_o = wr_stall_r;
	assign msg_valid_o = msg_valid_r;
	assign msg_thread_o = msg_thread_r;
	assign msg_fid_o = msg_fid_r;
	assign msg_desc_o = msg_desc_r;
	assign msg_mlen_o = msg_mlen_r;
	assign msg_eot_o = msg_eot_r;
	assign msg_data_o = msg_data_r;
	assign send_refused_o = refused_r;
	assign thread_end_o = end_r;
endmodule

/* File: sim/eur_props.sv */
/*
 Checker for the thread register file ports.
 Assumes binding into the design top with its FID_VALID value.
*/
`timescale 1ns/1ps
module eur_props #(
	parameter [15:0] FID_VALID = 16'h00FF
) (
	input wire clock_i,
	input wire rst_i,
	input wire rd_req_i,
	input wire [1:0] rd_file_i,
	input wire [7:0] rd_register_number_field_i,
	input wire [31:0] rd_imm_i,
	input wire [255:0] rd_data_o,
	input wire rd_valid_o,
	input wire rd_stall_o,
	input wire [3:0] rd_arf_type_o,
	input wire rd_arf_rsvd_o,
	input wire send_req_i,
	input wire [3:0] send_fid_i,
	input wire send_eot_i,
	input wire send_desc_imm_i,
	input wire [3:0] send_mlen_i,
	input wire send_dst_null_i,
	input wire msg_valid_o,
	input wire [3:0] msg_fid_o,
	input wire [3:0] msg_mlen_o,
	input wire send_refused_o,
	input wire thread_end_o
);
default clocking @(posedge clock_i); endclocking
default disable iff (rst_i);
sequence s_bad_eot;
	send_req_i && send_eot_i && send_desc_imm_i && !send_dst_null_i;
endsequence
sequence s_reg_eot;
	send_req_i && send_eot_i && !send_desc_imm_i;
endsequence
a_rd_answers: assert property (rd_req_i |=> rd_valid_o != rd_stall_o)
	else $error("read request without one answer");
a_rd_cause: assert property ((rd_valid_o || rd_stall_o) |-> $past(rd_req_i))
	else $error("read answer without request");
a_imm_operand: assert property (rd_req_i && rd_file_i == 2'h3 |=>
	rd_valid_o && rd_data_o[31:0] == $past(rd_imm_i)) else $error("immediate operand wrong");
a_arf_type: assert property (rd_req_i && rd_file_i == 2'h1 |=>
	{rd_arf_type_o, 4'h0} == ($past(rd_register_number_field_i) & 8'hF0)
	&& rd_arf_rsvd_o == ($past(rd_register_number_field_i[7:4]) inside {4'h5, 4'hE}))
	else $error("architecture type decode wrong");
a_eot_refused: assert property (s_bad_eot |=> send_refused_o && !thread_end_o)
	else $error("end flag with destination not refused");
a_eot_reg_desc: assert property (s_reg_eot |=> !thread_end_o)
	else $error("end flag honoured with register descriptor");
a_bad_fid: assert property (send_req_i && !FID_VALID[send_fid_i] |=> !msg_valid_o)
	else $error("invalid function id delivered");
a_msg_fields: assert property (msg_valid_o |-> $past(send_req_i)
	&& msg_fid_o == $past(send_fid_i) && msg_mlen_o == $past(send_mlen_i))
	else $error("message fields differ from send");
a_end_cause: assert property (thread_end_o |-> $past(send_eot_i)
	&& $past(send_desc_imm_i) && $past(send_dst_null_i)) else $error("spurious thread end");
a_refuse_cause: assert property (send_refused_o |-> $past(send_req_i))
	else $error("refusal without send");
endmodule
bind eur_thread_regfile eur_props #(.FID_VALID(FID_VALID)) i_eur_props (
	.clock_i(clock_i), .rst_i(rst_i), .rd_req_i(rd_req_i), .rd_file_i(rd_file_i),
	.rd_register_number_field_i(rd_register_number_field_i), .rd_imm_i(rd_imm_i), .rd_data_o(rd_data_o),
	.rd_valid_o(rd_valid_o), .rd_stall_o(rd_stall_o), .rd_arf_type_o(rd_arf_type_o),
	.rd_arf_rsvd_o(rd_arf_rsvd_o), .send_req_i(send_req_i), .send_fid_i(send_fid_i),
	.send_eot_i(send_eot_i), .send_desc_imm_i(send_desc_imm_i), .send_mlen_i(send_mlen_i),
	.send_dst_null_i(send_dst_null_i), .msg_valid_o(msg_valid_o), .msg_fid_o(msg_fid_o),
	.msg_mlen_o(msg_mlen_o), .send_refused_o(send_refused_o), .thread_end_o(thread_end_o));

/* File: sim/eur_sf_model.sv */
/*
 Shared-function model: answers the latest message with writebacks; a new message replaces one still pending.
 Assumes descriptor bits [4:0] count, [11:5] base, [12] slow reply,
 [13] bad payload (discarded), [14] unknown opcode (logged, no reply).
*/
`timescale 1ns/1ps
module eur_sf_model (
	input wire clock_i,
	input wire rst_i,
	input wire msg_valid_i,
	input wire msg_thread_i,
	input wire [31:0] msg_desc_i,
	output logic wb_valid_o = 0,
	output logic wb_thread_o = 0,
	output logic [6:0] wb_base_o = 0,
	output logic [4:0] wb_offset_o = 0,
	output logic [255:0] wb_data_o = 0
);
logic [31:0] desc_r = 0;
logic [5:0] wait_r = 0;
logic [4:0] left_r = 0;
logic [31:0] err_desc_r = 0;
logic err_thread_r = 0;
always @(posedge clock_i) begin
	wb_valid_o <= 0;
	wb_data_o <= ~wb_data_o;
	if (rst_i) begin
		left_r <= 0;
	end else if (msg_valid_i) begin
		desc_r <= msg_desc_i;
		wb_thread_o <= msg_thread_i;
		left_r <= (msg_desc_i[13] || msg_desc_i[14]) ? 5'd0 : msg_desc_i[4:0];
		if (msg_desc_i[14]) begin
			err_desc_r <= msg_desc_i;
			err_thread_r <= msg_thread_i;
		end
		wait_r <= msg_desc_i[12] ? 6'd30 : 6'd2;
	end else if (wait_r != 0) begin
		wait_r <= wait_r - 6'd1;
	end else if (left_r != 0) begin
		wb_valid_o <= 1;
		wb_base_o <= desc_r[11:5];
		wb_offset_o <= left_r - 5'd1;
		wb_data_o <= {8{desc_r ^ {27'h0, left_r - 5'd1}}};
		left_r <= left_r - 5'd1;
	end
end
endmodule

/* File: sim/eur_thread_regfile_tb_top.sv */
/*
 Bench for the thread register file: bus, operand and send sequences.
 Assumes the shared-function model on the message side.
*/
`timescale 1ns/1ps
module eur_thread_regfile_tb_top;
logic clock_i = 0, rst_i = 1, hsel_i = 0, hwrite_i = 0, rd_req_i = 0, rd_thread_i = 0;
logic rd_indirect_i = 0, wr_req_i = 0, wr_thread_i = 0, send_req_i = 0, send_thread_i = 0;
logic send_eot_i = 0, send_desc_imm_i = 1, send_dst_null_i = 0, hreadyout_o, hresp_o;
logic rd_valid_o, rd_stall_o, rd_arf_rsvd_o, wr_stall_o, msg_valid_o, msg_thread_o, msg_eot_o;
logic send_refused_o, thread_end_o, wb_valid_i, wb_thread_i, rv, rs, mv, rf, te;
logic [31:0] haddr_i = 0, hwdata_i = 0, rd_imm_i = 32'h5A5A0F0F, send_desc_i = 0, hrdata_o;
logic [31:0] msg_desc_o, q;
logic [1:0] htrans_i = 0, rd_file_i = 0, wr_file_i = 0, wr_esize_i = 0, wr_hstride_i = 0;
logic [2:0] hsize_i = 3'h2, rd_a0_sel_i = 0;
logic [7:0] rd_register_number_field_i = 0, wr_register_number_field_i = 0;
logic [4:0] rd_subreg_i = 0, wr_subreg_i = 0, send_rlen_i = 0, wb_offset_i;
logic [9:0] rd_imm_off_i = 0;
logic [5:0] wr_count_i = 0;
logic [3:0] send_fid_i = 0, send_mlen_i = 1, rd_arf_type_o, msg_fid_o, msg_mlen_o;
logic [6:0] send_src_reg_i = 0, send_dst_reg_i = 0, wb_base_i;
logic [255:0] wr_data_i = 0, wb_data_i, rd_data_o, msg_data_o, rd_q, d, e, f, m;
wire hready_i = hreadyout_o;
int num_errors = 0, n_checks = 0;
eur_thread_regfile i_eur_thread_regfile (.*);
eur_sf_model i_eur_sf_model (.clock_i(clock_i), .rst_i(rst_i), .msg_valid_i(msg_valid_o),
	.msg_thread_i(msg_thread_o), .msg_desc_i(msg_desc_o), .wb_valid_o(wb_valid_i),
	.wb_thread_o(wb_thread_i), .wb_base_o(wb_base_i), .wb_offset_o(wb_offset_i),
	.wb_data_o(wb_data_i));
always #4 clock_i = ~clock_i;
task automatic chk(input string nm, input logic [255:0] seen, exp);
	n_checks++;
	if (seen !== exp) begin
		num_errors++;
		$display("ERROR %s expected %h seen %h", nm, exp, seen);
	end
endtask
task automatic summarize;
	$display("checks %0d errors %0d", n_checks, num_errors);
	if (num_errors == 0 && n_checks > 0) begin
		$display("TB: PASS");
	end else begin
		$display("TB: FAIL");
	end
	$finish;
endtask
task automatic wt;
	int n = 0;
	do begin
		@(posedge clock_i);
		n++;
	end while (hready_i !== 1'b1 && n < 50);
	if (hready_i !== 1'b1) begin
		num_errors++;
		summarize;
	end
endtask
task automatic ahb(input logic w, input logic [31:0] a, dt);
	@(posedge clock_i);
	hsel_i <= 1;
	htrans_i <= 2'h2;
	haddr_i <= a;
	hwrite_i <= w;
	wt;
	hsel_i <= 0;
	htrans_i <= 2'h0;
	hwdata_i <= dt;
	wt;
	q = hrdata_o;
endtask
task automatic rd(input logic t, input logic [1:0] fl, input logic [7:0] r, input logic [4:0] s);
	@(posedge clock_i);
	rd_req_i <= 1;
	rd_thread_i <= t;
	rd_file_i <= fl;
	rd_register_number_field_i <= r;
	rd_subreg_i <= s;
	@(posedge clock_i);
	rd_req_i <= 0;
	#1 rd_q = rd_data_o;
	rv = rd_valid_o;
	rs = rd_stall_o;
endtask
task automatic wr(input logic t, input logic [1:0] fl, input logic [7:0] r,
	input logic [4:0] s, input logic [1:0] es, hs, input logic [5:0] c, input logic [255:0] dt);
	@(posedge clock_i);
	wr_req_i <= 1;
	wr_thread_i <= t;
	wr_file_i <= fl;
	wr_register_number_field_i <= r;
	wr_subreg_i <= s;
	wr_esize_i <= es;
	wr_hstride_i <= hs;
	wr_count_i <= c;
	wr_data_i <= dt;
	@(posedge clock_i);
	wr_req_i <= 0;
endtask
task automatic snd(input logic t, input logic [3:0] fid, input logic thread_end_flag, imm,
	input logic [31:0] desc, input logic dn, input logic [6:0] dst, input logic [4:0] rl);
	@(posedge clock_i);
	send_req_i <= 1;
	send_thread_i <= t;
	send_fid_i <= fid;
	send_eot_i <= thread_end_flag;
	send_desc_imm_i <= imm;
	send_desc_i <= desc;
	send_dst_null_i <= dn;
	send_dst_reg_i <= dst;
	send_rlen_i <= rl;
	@(posedge clock_i);
	send_req_i <= 0;
	#1 mv = msg_valid_o;
	rf = send_refused_o;
	te = thread_end_o;
endtask
task automatic poll(input logic [7:0] r);
	int n = 0;
	do begin
		rd(0, 0, r, 0);
		n++;
	end while (rs === 1'b1 && n < 40);
	if (rs !== 1'b0) begin
		num_errors++;
		summarize;
	end
endtask
initial begin
	for (int k = 0; k < 32; k++) d[8*k+:8] = k[7:0];
	e = ~d;
	f = d ^ {32{8'h80}};
	repeat (12) @(posedge clock_i);
	rst_i <= 0;
	ahb(0, 32'h00, 0);
	chk("ctrl", q, 32'h1);
	chk("hresp", hresp_o, 0);
	ahb(1, 32'h40, 32'hFFFFFFFF);
	ahb(0, 32'h40, 0);
	chk("unmapped", q, 0);
	for (int t = 0; t < 16; t++) begin
		wr(0, 1, {t[3:0], 4'h0}, 0, 2, 1, 8, '1);
		rd(0, 1, {t[3:0], 4'h0}, 0);
		chk("arf type", rd_arf_type_o, t);
		chk("arf rsvd", rd_arf_rsvd_o, t == 5 || t == 14);
		if (t != 1 && t != 12) chk("arf drop", rd_q, 0);
	end
	wr(0, 0, 5, 0, 2, 1, 8, d);
	wr(1, 0, 5, 0, 2, 1, 8, e);
	wr(0, 0, 6, 0, 2, 1, 8, f);
	wr(0, 0, 127, 0, 2, 1, 8, e);
	rd(0, 0, 5, 0);
	chk("r5 t0", rd_q, d);
	chk("rd valid", rv, 1);
	rd(1, 0, 5, 0);
	chk("r5 t1", rd_q, e);
	rd(0, 0, 127, 0);
	chk("r127", rd_q, e);
	rd(0, 0, 5, 4);
	chk("span", rd_q, {f[31:0], d[255:32]});
	rd(0, 3, 0, 0);
	chk("imm", rd_q[31:0], rd_imm_i);
	wr(0, 0, 7, 0, 2, 1, 8, d);
	wr(0, 0, 7, 1, 0, 2, 4, 0);
	m = d;
	for (int k = 0; k < 4; k++) m[8*(1+2*k)+:8] = 0;
	rd(0, 0, 7, 0);
	chk("mask", rd_q, m);
	wr(0, 1, 8'h10, 0, 1, 1, 8, {{128{1'b1}}, 128'hA0});
	wr(0, 1, 8'h10, 16, 1, 1, 8, '1);
	rd(0, 1, 8'h10, 0);
	chk("a0", rd_q, 256'hA0);
	rd_indirect_i <= 1;
	rd_imm_off_i <= 10'h020;
	rd(0, 0, 0, 0);
	rd_indirect_i <= 0;
	chk("indirect", rd_q, f);
	send_src_reg_i <= 5;
	snd(0, 1, 0, 1, 32'h1282, 0, 20, 2);
	chk("msg", {mv, msg_desc_o}, {1'b1, 32'h1282});
	chk("msg data", msg_data_o, d);
	rd(0, 0, 20, 0);
	chk("inflight", rs, 1);
	poll(21);
	chk("wb1", rd_q, {8{32'h1283}});
	poll(20);
	chk("wb0", rd_q, {8{32'h1282}});
	snd(0, 2, 0, 1, 32'h502, 0, 40, 3);
	poll(41);
	rd(0, 0, 42, 0);
	chk("surplus", rs, 1);
	wr(0, 0, 42, 0, 2, 1, 8, d);
	#1 chk("wr stall", wr_stall_o, 1);
	ahb(1, 32'h08, 32'h1);
	ahb(0, 32'h0C, 0);
	chk("infl data", q, 32'h400);
	snd(0, 9, 0, 1, 0, 0, 50, 1);
	chk("bad fid", mv, 0);
	ahb(0, 32'h10, 0);
	chk("drop cnt", q, 32'h1);
	rd(0, 0, 50, 0);
	chk("bad fid stuck", rs, 1);
	snd(0, 1, 0, 1, 32'h4A01, 0, 80, 1);
	snd(0, 1, 0, 1, 32'h2B41, 0, 90, 1);
	repeat (40) @(posedge clock_i);
	chk("sf error", i_eur_sf_model.err_desc_r, 32'h4A01);
	rd(0, 0, 90, 0);
	chk("discard stuck", rs, 1);
	snd(0, 1, 0, 1, 32'h781, 0, 60, 1);
	chk("overlap a", mv, 1);
	snd(0, 1, 0, 1, 32'h781, 0, 60, 1);
	chk("overlap b", mv, 1);
	snd(1, 1, 1, 1, 0, 0, 70, 1);
	chk("eot dst", {rf, te}, 2'b10);
	snd(1, 1, 0, 1, 0, 1, 0, 0);
	chk("hung", rf, 1);
	ahb(0, 32'h04, 0);
	chk("status hung", q, 32'h2);
	ahb(1, 32'h04, 32'h2);
	snd(1, 1, 1, 1, 0, 1, 0, 0);
	chk("eot", {mv, te, msg_eot_o, msg_thread_o}, 4'b1111);
	ahb(0, 32'h04, 0);
	chk("status done", q, 32'h20000);
	snd(0, 1, 1, 0, 0, 1, 0, 0);
	chk("eot reg", {mv, te, msg_eot_o, msg_desc_o}, {3'b100, 32'hA0});
	summarize;
end
endmodule
